/* core/ffc_consts.svh */
// Register indices, reset values, ranges and timing counts of the force filter chain
`ifndef FFC_CONSTS_SVH
`define FFC_CONSTS_SVH

`define FFC_ADDR_LAG_TC 4'h0
`define FFC_ADDR_LP_FREQ 4'h1
`define FFC_ADDR_LP_Q 4'h2
`define FFC_ADDR_NOTCH_SW 4'h3
`define FFC_ADDR_N1_FREQ 4'h4
`define FFC_ADDR_N1_Q 4'h5
`define FFC_ADDR_N1_DEPTH 4'h6
`define FFC_ADDR_N2_FREQ 4'h7
`define FFC_ADDR_N2_Q 4'h8
`define FFC_ADDR_N2_DEPTH 4'h9
`define FFC_ADDR_FORCE_OUT 4'hA
`define FFC_ADDR_FORCE_IN 4'hB

`define FFC_RST_LAG_TC 16'h0064
`define FFC_RST_LP_FREQ 16'h1388
`define FFC_RST_LP_Q 16'h0032
`define FFC_RST_NOTCH_SW 16'h0000
`define FFC_RST_N_FREQ 16'h1388
`define FFC_RST_N_Q 16'h0046
`define FFC_RST_N_DEPTH 16'h0000

`define FFC_LP_FREQ_MIN 16'h0064
`define FFC_LP_FREQ_BYPASS 16'h1388
`define FFC_LP_Q_MIN 16'h0032
`define FFC_LP_Q_MAX 16'h0064
`define FFC_N_FREQ_MIN 16'h0032
`define FFC_N_FREQ_MAX 16'h1388
`define FFC_N_Q_MIN 16'h0032
`define FFC_N_Q_MAX 16'h03E8
`define FFC_N_DEPTH_MAX 16'h03E8

`define FFC_NOTCH1_LSB 0
`define FFC_NOTCH2_LSB 8
`define FFC_NOTCH_ON 4'h1

`define FFC_CLK_NS 25
`define FFC_SAMPLE_NS 12500
`define FFC_SAMPLE_DIV (`FFC_SAMPLE_NS / `FFC_CLK_NS)
`define FFC_TC_UNIT_NS 10000
// 2*pi*2^24/80 kHz: integrator gain per Hz, scaled by 2^10 over Q14
`define FFC_FREQ_K 64'h0000000000000526
`define FFC_DAMP_NUM 64'h0000000000190000
`define FFC_ONE_Q14 64'h0000000000004000
`define FFC_DEPTH_FULL 64'h00000000000003E8

`endif

/* core/ffc_pkg.sv */
// Types shared by the force filter chain modules
package ffc_pkg;

  typedef struct packed {
    logic signed [31:0] lp;
    logic signed [31:0] bp;
    logic signed [15:0] y;
  } ffc_stage_st_t;

  typedef struct packed {
    logic [15:0] lag_tc;
    logic [15:0] lp_freq;
    logic [15:0] lp_q;
    logic [15:0] notch_sw;
    logic [15:0] n1_freq;
    logic [15:0] n1_q;
    logic [15:0] n1_depth;
    logic [15:0] n2_freq;
    logic [15:0] n2_q;
    logic [15:0] n2_depth;
    logic [15:0] div_cnt;
    logic strobe;
    logic strobe_d;
    logic signed [31:0] lag_acc;
    logic signed [15:0] force_out;
    logic force_valid;
    logic [15:0] rdata;
  } ffc_top_st_t;

endpackage

/* core/ffc_svf_stage.sv */
// One second-order state-variable stage, low-pass or notch, stepped once per sample
`include "ffc_consts.svh"

module ffc_svf_stage
  import ffc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic notch_mode_in,
  input wire logic enable_in,
  input wire logic [15:0] freq_in,
  input wire logic [15:0] q_in,
  input wire logic [15:0] depth_in,
  input wire logic signed [15:0] x_in,
  output logic signed [15:0] y_out
);

  ffc_stage_st_t st_q, st_d;

  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sd32767) begin
      return 16'sh7FFF;
    end else if (v < -64'sd32768) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  always_comb begin
    logic signed [63:0] xs, f, damp, g, hp, bp_n, lp_n, dbp;
    logic [15:0] q_c, fr_c, dp_c;
    st_d = st_q;
    q_c = q_in;
    fr_c = freq_in;
    dp_c = (depth_in > `FFC_N_DEPTH_MAX) ? `FFC_N_DEPTH_MAX : depth_in;
    if (notch_mode_in) begin
      if (q_c < `FFC_N_Q_MIN) q_c = `FFC_N_Q_MIN;
      if (q_c > `FFC_N_Q_MAX) q_c = `FFC_N_Q_MAX;
      if (fr_c < `FFC_N_FREQ_MIN) fr_c = `FFC_N_FREQ_MIN;
      if (fr_c > `FFC_N_FREQ_MAX) fr_c = `FFC_N_FREQ_MAX;
    end else begin
      if (q_c < `FFC_LP_Q_MIN) q_c = `FFC_LP_Q_MIN;
      if (q_c > `FFC_LP_Q_MAX) q_c = `FFC_LP_Q_MAX;
      if (fr_c < `FFC_LP_FREQ_MIN) fr_c = `FFC_LP_FREQ_MIN;
    end
    xs = 64'(x_in) <<< 8;
    // Centre or corner frequency sets the integrator gain
    f = (64'(fr_c) * `FFC_FREQ_K) >>> 10;
    // Higher Q gives less damping, hence narrower notch and more phase lag
    damp = `FFC_DAMP_NUM / 64'(q_c);
    // Depth scales how much band energy is removed at the centre
    g = ((`FFC_DEPTH_FULL - 64'(dp_c)) * `FFC_ONE_Q14) / `FFC_DEPTH_FULL;
    hp = xs - 64'(st_q.lp) - ((damp * 64'(st_q.bp)) >>> 14);
    bp_n = 64'(st_q.bp) + ((f * hp) >>> 14);
    lp_n = 64'(st_q.lp) + ((f * bp_n) >>> 14);
    dbp = (damp * bp_n) >>> 14;
    if (step_in) begin
      // Parked integrators track the input so a later enable starts without a jump
      if (!enable_in) begin
        st_d.lp = xs[31:0];
        st_d.bp = 32'sh0;
        st_d.y = x_in;
      end else begin
        st_d.lp = lp_n[31:0];
        st_d.bp = bp_n[31:0];
        if (notch_mode_in) begin
          st_d.y = sat16((xs - ((g * dbp) >>> 14)) >>> 8);
        end else begin
          st_d.y = sat16(lp_n >>> 8);
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign y_out = st_q.y;

  property p_stage_bypass;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (step_in && !enable_in) |=> (y_out == $past(x_in));
  endproperty
  a_stage_bypass: assert property (p_stage_bypass) else $error("disabled stage altered sample");

  property p_stage_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !step_in |=> $stable(y_out);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("stage output moved without step");

  property p_full_depth_pass;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (step_in && enable_in && notch_mode_in && depth_in == `FFC_N_DEPTH_MAX)
        |=> (y_out == $past(x_in));
  endproperty
  a_full_depth_pass: assert property (p_full_depth_pass) else $error("shallowest notch cut signal");

endmodule

/* core/ffc_filter_chain.sv */
// Force reference filter chain: lag stage, second-order low-pass, two notches
//
// Function
// - Lag stage, low-pass, then notches in series; each stage computes on its own.
// - Lag time constant 0..65535 in 0.01 ms, default 100, applied immediately.
// - Low-pass 100..5000 Hz default 5000, Q 0.50..1.00; 5000 Hz bypasses it.
// - Notch switches digit 0 enables notch 1, digit 2 notch 2; default off.
// - Each notch centre 50..5000 Hz, 1 Hz steps, default 5000.
// - Notch Q 0.50..10.00 default 0.70; larger Q narrows notch, adds lag.
// - Notch depth 0..1.000 in 0.001 steps, default 0, sets attenuation.
`include "ffc_consts.svh"

module ffc_filter_chain
  import ffc_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `FFC_SAMPLE_DIV
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic signed [15:0] force_ref_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic signed [15:0] force_out,
  output logic force_valid_out
);

  localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

  ffc_top_st_t st_q, st_d;
  logic signed [15:0] lag_y;
  logic signed [15:0] lp_y;
  logic signed [15:0] n1_y;
  logic signed [15:0] n2_y;
  logic lp_en;
  logic n1_en;
  logic n2_en;

  function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
    if (v > 64'sd32767) begin
      return 16'sh7FFF;
    end else if (v < -64'sd32768) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  function automatic logic notch_on(input logic [15:0] sw, input int unsigned lsb);
    return sw[lsb +: 4] == `FFC_NOTCH_ON;
  endfunction

  // Smoothing weight Ts/(tau+Ts) in Q16; one divider serves every time constant
  function automatic logic signed [63:0] lag_alpha(input logic [15:0] tc);
    logic [63:0] ts;
    ts = 64'(`FFC_SAMPLE_NS);
    return 64'((ts << 16) / (64'(tc) * 64'(`FFC_TC_UNIT_NS) + ts));
  endfunction

  assign lag_y = sat16(64'(st_q.lag_acc) >>> 8);
  assign lp_en = st_q.lp_freq < `FFC_LP_FREQ_BYPASS;
  assign n1_en = notch_on(st_q.notch_sw, `FFC_NOTCH1_LSB);
  assign n2_en = notch_on(st_q.notch_sw, `FFC_NOTCH2_LSB);

  // Each stage steps on the same strobe from its neighbour's registered output,
  // so no stage waits on another; the price is one sample of latency per stage
  ffc_svf_stage u_lowpass (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .step_in(st_q.strobe),
    .notch_mode_in(1'b0),
    .enable_in(lp_en),
    .freq_in(st_q.lp_freq),
    .q_in(st_q.lp_q),
    .depth_in(16'h0000),
    .x_in(lag_y),
    .y_out(lp_y)
  );

  ffc_svf_stage u_notch1 (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .step_in(st_q.strobe),
    .notch_mode_in(1'b1),
    .enable_in(n1_en),
    .freq_in(st_q.n1_freq),
    .q_in(st_q.n1_q),
    .depth_in(st_q.n1_depth),
    .x_in(lp_y),
    .y_out(n1_y)
  );

  ffc_svf_stage u_notch2 (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .step_in(st_q.strobe),
    .notch_mode_in(1'b1),
    .enable_in(n2_en),
    .freq_in(st_q.n2_freq),
    .q_in(st_q.n2_q),
    .depth_in(st_q.n2_depth),
    .x_in(n1_y),
    .y_out(n2_y)
  );

  always_comb begin
    logic signed [63:0] xs;
    logic signed [63:0] step;
    st_d = st_q;
    xs = 64'(force_ref_in) <<< 8;
    step = (((xs - 64'(st_q.lag_acc)) * lag_alpha(st_q.lag_tc)) >>> 16);

    // Sample-rate enable
    if (st_q.div_cnt == DIV_LAST) begin
      st_d.div_cnt = 16'h0000;
      st_d.strobe = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 16'h0001;
      st_d.strobe = 1'b0;
    end
    st_d.strobe_d = st_q.strobe;

    if (st_q.strobe) begin
      if (st_q.lag_tc == 16'h0000) begin
        st_d.lag_acc = xs[31:0];
      end else begin
        st_d.lag_acc = 32'(64'(st_q.lag_acc) + step);
      end
    end

    // Notch 2 settles one edge after the strobe, the output one edge later
    st_d.force_out = n2_y;
    st_d.force_valid = st_q.strobe_d;

    // New settings are used from the next sample on, with no restart
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `FFC_ADDR_LAG_TC: st_d.lag_tc = reg_wdata_in;
        `FFC_ADDR_LP_FREQ: st_d.lp_freq = reg_wdata_in;
        `FFC_ADDR_LP_Q: st_d.lp_q = reg_wdata_in;
        `FFC_ADDR_NOTCH_SW: st_d.notch_sw = reg_wdata_in;
        `FFC_ADDR_N1_FREQ: st_d.n1_freq = reg_wdata_in;
        `FFC_ADDR_N1_Q: st_d.n1_q = reg_wdata_in;
        `FFC_ADDR_N1_DEPTH: st_d.n1_depth = reg_wdata_in;
        `FFC_ADDR_N2_FREQ: st_d.n2_freq = reg_wdata_in;
        `FFC_ADDR_N2_Q: st_d.n2_q = reg_wdata_in;
        `FFC_ADDR_N2_DEPTH: st_d.n2_depth = reg_wdata_in;
        default: ;
      endcase
    end

    // Read data stand only in the cycle after the read request
    st_d.rdata = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `FFC_ADDR_LAG_TC: st_d.rdata = st_q.lag_tc;
        `FFC_ADDR_LP_FREQ: st_d.rdata = st_q.lp_freq;
        `FFC_ADDR_LP_Q: st_d.rdata = st_q.lp_q;
        `FFC_ADDR_NOTCH_SW: st_d.rdata = st_q.notch_sw;
        `FFC_ADDR_N1_FREQ: st_d.rdata = st_q.n1_freq;
        `FFC_ADDR_N1_Q: st_d.rdata = st_q.n1_q;
        `FFC_ADDR_N1_DEPTH: st_d.rdata = st_q.n1_depth;
        `FFC_ADDR_N2_FREQ: st_d.rdata = st_q.n2_freq;
        `FFC_ADDR_N2_Q: st_d.rdata = st_q.n2_q;
        `FFC_ADDR_N2_DEPTH: st_d.rdata = st_q.n2_depth;
        `FFC_ADDR_FORCE_OUT: st_d.rdata = st_q.force_out;
        `FFC_ADDR_FORCE_IN: st_d.rdata = lag_y;
        default: st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
      st_q.lag_tc <= `FFC_RST_LAG_TC;
      st_q.lp_freq <= `FFC_RST_LP_FREQ;
      st_q.lp_q <= `FFC_RST_LP_Q;
      st_q.notch_sw <= `FFC_RST_NOTCH_SW;
      st_q.n1_freq <= `FFC_RST_N_FREQ;
      st_q.n1_q <= `FFC_RST_N_Q;
      st_q.n1_depth <= `FFC_RST_N_DEPTH;
      st_q.n2_freq <= `FFC_RST_N_FREQ;
      st_q.n2_q <= `FFC_RST_N_Q;
      st_q.n2_depth <= `FFC_RST_N_DEPTH;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign force_out = st_q.force_out;
  assign force_valid_out = st_q.force_valid;

  // Checks

  sequence s_lag_write;
    reg_wr_in && reg_addr_in == `FFC_ADDR_LAG_TC;
  endsequence

  property p_lag_write_now;
    @(posedge mclk_in) disable iff (!rst_n_in)
      s_lag_write |=> (st_q.lag_tc == $past(reg_wdata_in));
  endproperty
  a_lag_write_now: assert property (p_lag_write_now) else $error("lag setting not taken");

  property p_lag_passthrough;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (st_q.strobe && st_q.lag_tc == 16'h0000) |=> (lag_y == $past(force_ref_in));
  endproperty
  a_lag_passthrough: assert property (p_lag_passthrough) else $error("zero lag not transparent");

  property p_lag_moves_toward;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (st_q.strobe && st_q.lag_tc != 16'h0000 && 64'(force_ref_in) <<< 8 > 64'(st_q.lag_acc))
        |=> (st_q.lag_acc >= $past(st_q.lag_acc));
  endproperty
  a_lag_moves_toward: assert property (p_lag_moves_toward) else $error("lag moved away");

  property p_lp_bypass;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (st_q.strobe && st_q.lp_freq == `FFC_LP_FREQ_BYPASS) |=> (lp_y == $past(lag_y));
  endproperty
  a_lp_bypass: assert property (p_lp_bypass) else $error("low-pass not bypassed at 5000");

  sequence s_notch1_off;
    st_q.strobe && st_q.notch_sw[3:0] != `FFC_NOTCH_ON;
  endsequence

  property p_notch1_off;
    @(posedge mclk_in) disable iff (!rst_n_in)
      s_notch1_off |=> (n1_y == $past(lp_y));
  endproperty
  a_notch1_off: assert property (p_notch1_off) else $error("disabled notch 1 acted");

  property p_notch2_off;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (st_q.strobe && st_q.notch_sw[11:8] != `FFC_NOTCH_ON) |=> (n2_y == $past(n1_y));
  endproperty
  a_notch2_off: assert property (p_notch2_off) else $error("disabled notch 2 acted");

  sequence s_sample_step;
    st_q.strobe ##1 1'b1;
  endsequence

  property p_valid_follows;
    @(posedge mclk_in) disable iff (!rst_n_in)
      s_sample_step |=> (force_valid_out && force_out == $past(n2_y));
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("output not valid 2 after strobe");

  property p_read_data;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == `FFC_ADDR_NOTCH_SW)
        |=> (reg_rdata_out == $past(st_q.notch_sw));
  endproperty
  a_read_data: assert property (p_read_data) else $error("notch switch readback wrong");

  property p_rdata_idle;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !reg_rd_in |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_strobe_at_wrap;
    @(posedge mclk_in) disable iff (!rst_n_in)
      st_q.strobe |-> (st_q.div_cnt == 16'h0000);
  endproperty
  a_strobe_at_wrap: assert property (p_strobe_at_wrap) else $error("strobe off wrap");

  property p_valid_single;
    @(posedge mclk_in) disable iff (!rst_n_in)
      force_valid_out |=> !force_valid_out;
  endproperty
  a_valid_single: assert property (p_valid_single) else $error("valid wider than one cycle");

  // Output may only move in the cycle that valid marks
  property p_out_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !st_q.strobe_d |=> $stable(force_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("force output moved between samples");

  property p_lag_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !st_q.strobe |=> $stable(st_q.lag_acc);
  endproperty
  a_lag_hold: assert property (p_lag_hold) else $error("lag state moved without strobe");

  property p_ro_write_ignored;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in >= `FFC_ADDR_FORCE_OUT)
        |=> (st_q.lag_tc == $past(st_q.lag_tc) && st_q.notch_sw == $past(st_q.notch_sw));
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write landed");

  property p_unmapped_read;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in > `FFC_ADDR_FORCE_IN) |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_sw_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !reg_wr_in |=> $stable(st_q.notch_sw);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("notch switches moved without write");

  property p_lp_freq_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_LP_FREQ)
        |=> (st_q.lp_freq == $past(reg_wdata_in));
  endproperty
  a_lp_freq_write: assert property (p_lp_freq_write) else $error("low-pass frequency not taken");

  property p_lp_q_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_LP_Q)
        |=> (st_q.lp_q == $past(reg_wdata_in));
  endproperty
  a_lp_q_write: assert property (p_lp_q_write) else $error("low-pass Q not taken");

  property p_n1_freq_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N1_FREQ)
        |=> (st_q.n1_freq == $past(reg_wdata_in));
  endproperty
  a_n1_freq_write: assert property (p_n1_freq_write) else $error("notch 1 centre not taken");

  property p_n1_q_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N1_Q)
        |=> (st_q.n1_q == $past(reg_wdata_in));
  endproperty
  a_n1_q_write: assert property (p_n1_q_write) else $error("notch 1 Q not taken");

  property p_n1_depth_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N1_DEPTH)
        |=> (st_q.n1_depth == $past(reg_wdata_in));
  endproperty
  a_n1_depth_write: assert property (p_n1_depth_write) else $error("notch 1 depth not taken");

  property p_n2_freq_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N2_FREQ)
        |=> (st_q.n2_freq == $past(reg_wdata_in));
  endproperty
  a_n2_freq_write: assert property (p_n2_freq_write) else $error("notch 2 centre not taken");

  property p_n2_q_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N2_Q)
        |=> (st_q.n2_q == $past(reg_wdata_in));
  endproperty
  a_n2_q_write: assert property (p_n2_q_write) else $error("notch 2 Q not taken");

  property p_n2_depth_write;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == `FFC_ADDR_N2_DEPTH)
        |=> (st_q.n2_depth == $past(reg_wdata_in));
  endproperty
  a_n2_depth_write: assert property (p_n2_depth_write) else $error("notch 2 depth not taken");

endmodule

/* tb/ffc_speed_loop_model.sv */
// Speed loop stand-in: drives the force reference and reports the lag ceiling
module ffc_speed_loop_model #(
  parameter int unsigned SPEED_GAIN_HZ = 30
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic signed [15:0] level_in,
  output logic signed [15:0] force_ref_out,
  output logic [15:0] lag_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Stable-control ceiling in 0.01 ms units, keeping a factor 4 margin on the loop gain
  assign lag_limit_out = 16'(100000000 / (6283 * SPEED_GAIN_HZ * 4));

  // The loop updates its output just after a clock edge, or at once when rst_n_in falls
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_ref_out <= 16'sh0000;
    end else begin
      force_ref_out <= level_in;
    end
  end
endmodule

/* tb/ffc_filter_chain_tb.sv */
// Self-checking bench for the force reference filter chain
module ffc_filter_chain_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short sample period keeps the run brief; only exact bypass cases are compared
  localparam int unsigned SDIV = 10;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic signed [15:0] level = 16'sh0000;
  logic signed [15:0] force_ref;
  logic [15:0] lag_limit;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_out;
  logic signed [15:0] force_out;
  logic force_valid_out;
  int n_errors = 0;
  int tests_run = 0;

  always #12.5 mclk_in = ~mclk_in;

  ffc_speed_loop_model u_ffc_speed_loop_model (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .level_in(level),
    .force_ref_out(force_ref), .lag_limit_out(lag_limit)
  );

  ffc_filter_chain #(.SAMPLE_DIV(SDIV)) u_ffc_filter_chain (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .force_ref_in(force_ref),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata_out), .force_out(force_out),
    .force_valid_out(force_valid_out)
  );

  function automatic logic [15:0] reset_of(input logic [3:0] a);
    case (a)
      4'h0: return 16'h0064;
      4'h1, 4'h4, 4'h7: return 16'h1388;
      4'h2: return 16'h0032;
      4'h5, 4'h8: return 16'h0046;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic signed [15:0] rnd_level();
    return 16'($signed(16'($urandom_range(0, 40000))) - 16'sd20000);
  endfunction

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_force(input logic signed [15:0] got, input logic signed [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: force %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_true(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask

  // Read data stands for one cycle only, then the port returns to zero
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_out;
    @(posedge mclk_in);
    #1 chk_reg(reg_rdata_out, 16'h0000);
  endtask

  task automatic wait_valid(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge mclk_in);
        k++;
      end while (force_valid_out !== 1'b1 && k < 4 * SDIV);
      chk_true(k < 4 * SDIV, "no output sample");
    end
    #1;
  endtask

  task automatic settle(input logic signed [15:0] v);
    @(posedge mclk_in);
    level <= v;
    wait_valid(5);
  endtask

  task automatic set_chain(input logic [15:0] lag, input logic [15:0] lpf,
                           input logic [15:0] sw, input logic [15:0] dep);
    reg_write(4'h0, lag);
    reg_write(4'h1, lpf);
    reg_write(4'h3, sw);
    reg_write(4'h6, dep);
    reg_write(4'h9, dep);
  endtask

  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  initial begin
    logic [15:0] r;
    logic [15:0] v;
    int k;
    void'($urandom(93548));
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 10; a++) begin
      reg_read(4'(a), r);
      chk_reg(r, reset_of(4'(a)));
    end
    reg_read(4'hC, r);
    chk_reg(r, 16'h0000);
    // Motor at rest here, so notch centres may be rewritten freely
    for (int a = 0; a < 10; a++) begin
      v = 16'($urandom);
      reg_write(4'(a), v);
      reg_read(4'(a), r);
      chk_reg(r, v);
      reg_write(4'(a), reset_of(4'(a)));
    end
    reg_write(4'hA, 16'h1234);
    reg_read(4'hA, r);
    chk_reg(r, 16'h0000);
    // Everything bypassed: each sample arrives unchanged
    set_chain(16'h0000, 16'h1388, 16'h0000, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : 16'(rnd_level());
      settle(v);
      chk_force(force_out, v);
    end
    wait_valid(1);
    chk_true(force_valid_out === 1'b0, "valid wider than one cycle");
    k = 0;
    while (force_valid_out !== 1'b1 && k < 4 * SDIV) begin
      @(posedge mclk_in);
      k++;
    end
    chk_true(k == SDIV, "sample spacing");
    // Lag within the loop's stable ceiling holds the step back, zero releases it at once
    settle(16'sh0000);
    reg_write(4'h0, lag_limit);
    settle(16'sd10000);
    chk_true(force_out > 16'sh0000 && force_out < level, "lag stage did not smooth");
    reg_write(4'h0, 16'h0000);
    wait_valid(5);
    chk_force(force_out, level);
    // Second-order stage active below 5000 Hz, bypassed again at 5000
    settle(16'sh0000);
    reg_write(4'h1, 16'($urandom_range(100, 1000)));
    settle(16'sd10000);
    chk_true(force_out < level, "low-pass did not smooth");
    reg_write(4'h1, 16'h1388);
    wait_valid(5);
    chk_force(force_out, level);
    // Notches at 1000 Hz, full depth: notch 1 alone, notch 2 alone, then both off, then both shallow
    settle(16'sh0000);
    reg_write(4'h4, 16'h03E8);
    reg_write(4'h7, 16'h03E8);
    for (int m = 0; m < 3; m++) begin
      set_chain(16'h0000, 16'h1388, 16'h0001 << (8 * m), 16'h0000);
      settle(16'sh0000);
      settle(16'sd10000);
      chk_true(m == 2 ? force_out === level : force_out !== level, "notch switch");
    end
    set_chain(16'h0000, 16'h1388, 16'h0101, 16'h03E8);
    settle(16'sh0000);
    settle(rnd_level());
    chk_force(force_out, level);
    // Reset in mid-run clears outputs and restores settings
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    #1 chk_force(force_out, 16'sh0000);
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    reg_read(4'h0, r);
    chk_reg(r, 16'h0064);
    reg_read(4'h3, r);
    chk_reg(r, 16'h0000);
    close_out();
  end
endmodule
